// file: verilog/tsoc_cfg_top.sv
// reference-select, aux-loop routing and output pin enable configuration
// assumes a synchronous 8-bit register port and pins synchronous to core_clk
//
// Functional notes
// - code 0001 rate follows rate-family bit
// - rate-family bit defaults from strap at reset
// - revertive main loop switches to better input
// - nonrevertive updates top priority entry, switches only when selected input goes invalid
// - aux loop always revertive
// - follow=1, source=0: outputs from main loop
// - follow=0: aux analog source picks loop
// - force codes select inputs or automatic
// - forced input becomes top and selected
// - monitors keep updating while forced
// - forced aux loop never switches away
// - reserved bits store and read back, except aux force bits 6:4 and output enable bit 7, which read as zero
// - legacy format bits store, no effect
// - out5 and out5b low unless enabled
// - out4 and out4b low unless enabled
// - out3b pin is gpio unless enabled
// - out2b pin is gpio unless enabled
// - out1b pin is gpio unless enabled
`timescale 1ns/1ns
`default_nettype none
module tsoc_cfg_top
   import tsoc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // strap pin
   input wire logic rate_strap,
   // settings held by neighbouring registers
   input wire logic aux_analog_source_select,
   input wire logic [3:0] aux_analog_frequency,
   // input clock monitor results, bit n-1 is input n
   input wire logic [8:0] input_valid,
   // frequency code of an input, decoded against the rate family
   input wire logic [3:0] input_freq_code,
   output logic input_rate_is_1544,
   output logic input_rate_is_2048,
   // loop selection
   output logic [3:0] main_selected,
   output logic [3:0] main_top_priority,
   output logic [3:0] aux_selected,
   output logic [3:0] aux_top_priority,
   output logic aux_forced_active,
   // analog loop routing
   output logic all_outputs_from_main,
   output logic aux_analog_from_main,
   output logic [3:0] aux_analog_freq_out,
   output logic aux_analog_freq_apply,
   // clocks picked by the frequency select fields
   input wire logic out5_clk_src,
   input wire logic out4_clk_src,
   input wire logic out3_clk_src,
   input wire logic out2_clk_src,
   input wire logic out1_clk_src,
   // dedicated output pins
   output logic out5_pin,
   output logic out5b_pin,
   output logic out4_pin,
   output logic out4b_pin,
   // shared pins, index 0..2 is out1b/gpio1 .. out3b/gpio3
   input wire logic [2:0] gpio_dout,
   input wire logic [2:0] gpio_oe_n,
   output logic [2:0] gpio_din,
   input wire logic [2:0] shared_pin_in,
   output logic [2:0] shared_pin_out,
   output logic [2:0] shared_pin_oe_n
);
   tsoc_init_t init_r;
   logic strap_r;
   logic [7:0] mode_r;
   logic [7:0] aux_force_r;
   logic [7:0] legacy_r;
   logic [7:0] out_en_r;
   logic [7:0] rdata_nxt;
   logic wr_mode;
   logic wr_aux;
   logic wr_legacy;
   logic wr_oe;
   logic follow;
   logic [3:0] ded_clk;
   logic [3:0] ded_sel;
   logic [3:0] ded_out;
   logic [2:0] sh_clk;
   logic [2:0] sh_sel;

   tsoc_sel_if main_if ();
   tsoc_sel_if aux_if ();

   // strap follows the pin while reset is held, frozen after release
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         strap_r <= rate_strap;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         init_r <= TSOC_INIT_STRAP;
      end
      else
      begin
         case (init_r)
            TSOC_INIT_STRAP: init_r <= TSOC_INIT_DONE;
            TSOC_INIT_DONE: init_r <= TSOC_INIT_DONE;
            default: init_r <= TSOC_INIT_DONE;
         endcase
      end
   end

   assign wr_mode = reg_wr_en && reg_addr == TSOC_ADDR_MODE;
   assign wr_aux = reg_wr_en && reg_addr == TSOC_ADDR_AUX_FORCE;
   assign wr_legacy = reg_wr_en && reg_addr == TSOC_ADDR_LEGACY;
   assign wr_oe = reg_wr_en && reg_addr == TSOC_ADDR_OUT_EN;

   // mode register: a write in the strap cycle still wins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_r <= TSOC_RST_MODE;
      end
      else if (wr_mode)
      begin
         mode_r <= reg_wdata;
      end
      else if (init_r == TSOC_INIT_STRAP)
      begin
         mode_r[TSOC_MODE_RATE_BIT] <= strap_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         aux_force_r <= TSOC_RST_AUX_FORCE;
      end
      else if (wr_aux)
      begin
         aux_force_r <= reg_wdata & TSOC_AUXF_RD_MASK;
      end
   end

   // reserved and legacy format bits are plain storage
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         legacy_r <= TSOC_RST_LEGACY;
      end
      else if (wr_legacy)
      begin
         legacy_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         out_en_r <= TSOC_RST_OUT_EN;
      end
      else if (wr_oe)
      begin
         out_en_r <= reg_wdata & TSOC_OE_RD_MASK;
      end
   end

   // read data one cycle after the strobe, unmapped reads give zero
   always_comb
   begin
      case (reg_addr)
         TSOC_ADDR_MODE: rdata_nxt = mode_r;
         TSOC_ADDR_AUX_FORCE: rdata_nxt = aux_force_r;
         TSOC_ADDR_LEGACY: rdata_nxt = legacy_r;
         TSOC_ADDR_OUT_EN: rdata_nxt = out_en_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd_en;
         if (reg_rd_en)
         begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // input rate decode for frequency code 0001
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         input_rate_is_1544 <= 1'b0;
         input_rate_is_2048 <= 1'b0;
      end
      else
      begin
         input_rate_is_1544 <= input_freq_code == TSOC_FREQ_CODE_FAMILY &&
                               mode_r[TSOC_MODE_RATE_BIT];
         input_rate_is_2048 <= input_freq_code == TSOC_FREQ_CODE_FAMILY &&
                               !mode_r[TSOC_MODE_RATE_BIT];
      end
   end

   // monitor results reach both selectors untouched, forced or not
   assign main_if.valid = input_valid;
   assign aux_if.valid = input_valid;
   assign main_if.revertive = mode_r[TSOC_MODE_REVERTIVE_SELECT_BIT];
   assign main_if.force_code = TSOC_FORCE_AUTO;
   assign aux_if.revertive = 1'b1;
   assign aux_if.force_code = aux_force_r[3:0];

   tsoc_ref_sel u_main_sel (
      .core_clk(core_clk),
      .rst(rst),
      .sel(main_if.loop)
   );

   tsoc_ref_sel u_aux_sel (
      .core_clk(core_clk),
      .rst(rst),
      .sel(aux_if.loop)
   );

   assign main_selected = main_if.selected;
   assign main_top_priority = main_if.top;
   assign aux_selected = aux_if.selected;
   assign aux_top_priority = aux_if.top;
   assign aux_forced_active = aux_if.forced;

   // analog loop routing
   assign follow = aux_force_r[TSOC_AUXF_FOLLOW_BIT];
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         all_outputs_from_main <= 1'b0;
         aux_analog_from_main <= 1'b0;
         aux_analog_freq_out <= 4'h0;
         aux_analog_freq_apply <= 1'b0;
      end
      else
      begin
         all_outputs_from_main <= follow && !aux_analog_source_select;
         aux_analog_from_main <= follow || aux_analog_source_select;
         aux_analog_freq_apply <= follow && !aux_analog_source_select;
         aux_analog_freq_out <= aux_analog_frequency;
      end
   end

   // dedicated pins: out5, out5b, out4, out4b
   assign ded_clk = {out5_clk_src, out5_clk_src, out4_clk_src, out4_clk_src};
   assign ded_sel = {out_en_r[TSOC_OE_OUT5_BIT], out_en_r[TSOC_OE_OUT5B_BIT],
                     out_en_r[TSOC_OE_OUT4_BIT], out_en_r[TSOC_OE_OUT4B_BIT]};

   for (genvar g = 0; g < 4; g++)
   begin : g_ded
      // disabled pins drive low
      tsoc_pin_drv u_pin (
         .core_clk(core_clk),
         .rst(rst),
         .clk_sel(ded_sel[g]),
         .clk_src(ded_clk[g]),
         .alt_dout(1'b0),
         .alt_oe_n(1'b0),
         .pin_out(ded_out[g]),
         .pin_oe_n()
      );
   end

   assign out5_pin = ded_out[3];
   assign out5b_pin = ded_out[2];
   assign out4_pin = ded_out[1];
   assign out4b_pin = ded_out[0];

   // shared pins: out3b, out2b and out1b follow their own frequency fields
   assign sh_clk = {out3_clk_src, out2_clk_src, out1_clk_src};
   assign sh_sel = {out_en_r[TSOC_OE_OUT3B_BIT], out_en_r[TSOC_OE_OUT2B_BIT],
                    out_en_r[TSOC_OE_OUT1B_BIT]};

   for (genvar g = 0; g < 3; g++)
   begin : g_shared
      tsoc_pin_drv u_pin (
         .core_clk(core_clk),
         .rst(rst),
         .clk_sel(sh_sel[g]),
         .clk_src(sh_clk[g]),
         .alt_dout(gpio_dout[g]),
         .alt_oe_n(gpio_oe_n[g]),
         .pin_out(shared_pin_out[g]),
         .pin_oe_n(shared_pin_oe_n[g])
      );
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         gpio_din <= 3'h0;
      end
      else
      begin
         gpio_din <= shared_pin_in;
      end
   end
endmodule : tsoc_cfg_top
`default_nettype wire

// file: inc/tsoc_pkg.sv
// constants of the reference-select and output-enable configuration block
// assumes one 100 MHz core clock and an 8-bit register port
package tsoc_pkg;
   // register offsets
   localparam logic [7:0] TSOC_ADDR_MODE = 8'h34;
   localparam logic [7:0] TSOC_ADDR_AUX_FORCE = 8'h35;
   localparam logic [7:0] TSOC_ADDR_LEGACY = 8'h36;
   localparam logic [7:0] TSOC_ADDR_OUT_EN = 8'h37;
   // reset values (mode bit 2 is overwritten from the strap)
   localparam logic [7:0] TSOC_RST_MODE = 8'hca;
   localparam logic [7:0] TSOC_RST_AUX_FORCE = 8'h00;
   localparam logic [7:0] TSOC_RST_LEGACY = 8'h00;
   localparam logic [7:0] TSOC_RST_OUT_EN = 8'h60;
   // mode register fields
   localparam int TSOC_MODE_RATE_BIT = 2;
   localparam int TSOC_MODE_REVERTIVE_SELECT_BIT = 0;
   // aux force register fields
   localparam int TSOC_AUXF_FOLLOW_BIT = 7;
   localparam logic [7:0] TSOC_AUXF_RD_MASK = 8'h8f;
   // output enable register fields
   localparam int TSOC_OE_OUT5_BIT = 6;
   localparam int TSOC_OE_OUT4_BIT = 5;
   localparam int TSOC_OE_OUT5B_BIT = 4;
   localparam int TSOC_OE_OUT4B_BIT = 3;
   localparam int TSOC_OE_OUT3B_BIT = 2;
   localparam int TSOC_OE_OUT2B_BIT = 1;
   localparam int TSOC_OE_OUT1B_BIT = 0;
   localparam logic [7:0] TSOC_OE_RD_MASK = 8'h7f;
   // input clocks and force codes
   localparam int TSOC_NUM_INPUTS = 9;
   localparam int TSOC_ABSENT_INPUT = 7;
   localparam logic [3:0] TSOC_FORCE_AUTO = 4'h0;
   localparam logic [3:0] TSOC_FORCE_AUTO_ALT = 4'hf;
   localparam logic [3:0] TSOC_FORCE_LAST_LOW = 4'h6;
   localparam logic [3:0] TSOC_FORCE_IN8 = 4'h8;
   localparam logic [3:0] TSOC_FORCE_IN9 = 4'h9;
   localparam logic [3:0] TSOC_REF_NONE = 4'h0;
   // frequency code whose rate follows the rate-family bit
   localparam logic [3:0] TSOC_FREQ_CODE_FAMILY = 4'h1;
   localparam int TSOC_AUX_FREQ_W = 4;
   typedef logic [3:0] tsoc_ref_t;
   typedef enum {TSOC_INIT_STRAP, TSOC_INIT_DONE} tsoc_init_t;
endpackage : tsoc_pkg

// file: inc/tsoc_sel_if.sv
// carrier between the top and a reference selector
// assumes both ends run on the core clock
`timescale 1ns/1ns
`default_nettype none
interface tsoc_sel_if;
   logic [8:0] valid;
   logic revertive;
   logic [3:0] force_code;
   logic [3:0] selected;
   logic [3:0] top;
   logic forced;
   modport loop (input valid, input revertive, input force_code,
                 output selected, output top, output forced);
   modport ctrl (output valid, output revertive, output force_code,
                 input selected, input top, input forced);
endinterface : tsoc_sel_if
`default_nettype wire

// file: verilog/tsoc_ref_sel.sv
// reference selector of one loop: priority table top entry and selection
// assumes input n is bit n-1 of valid and lower number is higher priority
`timescale 1ns/1ns
`default_nettype none
module tsoc_ref_sel
   import tsoc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // selector carrier
   tsoc_sel_if.loop sel
);
   logic [3:0] first_valid;
   logic force_ok;
   logic [3:0] sel_r;
   logic [3:0] sel_nxt;
   logic [3:0] top_r;
   logic [3:0] top_nxt;
   logic forced_r;
   logic cur_valid;

   always_comb
   begin
      first_valid = TSOC_REF_NONE;
      for (int i = TSOC_NUM_INPUTS; i >= 1; i--)
      begin
         if (i != TSOC_ABSENT_INPUT && sel.valid[i-1])
         begin
            first_valid = 4'(i);
         end
      end
   end

   // unused codes fall back to automatic selection
   assign force_ok = (sel.force_code != TSOC_FORCE_AUTO &&
                      sel.force_code <= TSOC_FORCE_LAST_LOW) ||
                     sel.force_code == TSOC_FORCE_IN8 ||
                     sel.force_code == TSOC_FORCE_IN9;

   assign cur_valid = (sel_r != TSOC_REF_NONE) && sel.valid[sel_r - 4'h1];

   always_comb
   begin
      top_nxt = force_ok ? sel.force_code : first_valid;
      if (force_ok)
      begin
         sel_nxt = sel.force_code;
      end
      else if (sel.revertive)
      begin
         sel_nxt = first_valid;
      end
      else if (!cur_valid)
      begin
         sel_nxt = first_valid;
      end
      else
      begin
         sel_nxt = sel_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_r <= TSOC_REF_NONE;
         top_r <= TSOC_REF_NONE;
         forced_r <= 1'b0;
      end
      else
      begin
         sel_r <= sel_nxt;
         top_r <= top_nxt;
         forced_r <= force_ok;
      end
   end

   assign sel.selected = sel_r;
   assign sel.top = top_r;
   assign sel.forced = forced_r;
endmodule : tsoc_ref_sel
`default_nettype wire

// file: verilog/tsoc_pin_drv.sv
// one output-clock pin, optionally shared with a general i/o function
// assumes clk_src is already the clock picked by the frequency select field
`timescale 1ns/1ns
`default_nettype none
module tsoc_pin_drv
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic clk_sel,
   input wire logic clk_src,
   // alternate general i/o drive
   input wire logic alt_dout,
   input wire logic alt_oe_n,
   // pin
   output logic pin_out,
   output logic pin_oe_n
);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end
      else if (clk_sel)
      begin
         pin_out <= clk_src;
         pin_oe_n <= 1'b0;
      end
      else
      begin
         pin_out <= alt_dout;
         pin_oe_n <= alt_oe_n;
      end
   end
endmodule : tsoc_pin_drv
`default_nettype wire

// file: tb/tsoc_cfg_properties.sv
// port relations of the configuration block
// assumes it is bound to tsoc_cfg_top
`timescale 1ns/1ns
`default_nettype none
module tsoc_cfg_properties
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // watched ports
   input wire logic [8:0] input_valid,
   input wire logic [3:0] input_freq_code,
   input wire logic input_rate_is_1544,
   input wire logic input_rate_is_2048,
   input wire logic [3:0] main_selected,
   input wire logic [3:0] main_top_priority,
   input wire logic [3:0] aux_selected,
   input wire logic [3:0] aux_top_priority,
   input wire logic aux_forced_active,
   input wire logic all_outputs_from_main,
   input wire logic aux_analog_from_main,
   input wire logic aux_analog_freq_apply,
   input wire logic [3:0] aux_analog_frequency,
   input wire logic [3:0] aux_analog_freq_out,
   input wire logic out5_clk_src,
   input wire logic out5_pin,
   input wire logic [2:0] shared_pin_in,
   input wire logic [2:0] gpio_din
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // lowest-numbered valid input, input 7 does not exist
   function automatic logic [3:0] best(input logic [8:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 8; i >= 0; i--)
      begin
         if (v[i] && i != 6)
         begin
            r = 4'(i + 1);
         end
      end
      return r;
   endfunction : best
   a_rate_one_hot: assert property (!$past(rst) &&
      $past(input_freq_code) == 4'h1 |->
      input_rate_is_1544 != input_rate_is_2048) else $error("rate decode");
   a_rate_code_only: assert property (input_rate_is_1544 ||
      input_rate_is_2048 |-> $past(input_freq_code) == 4'h1)
      else $error("rate without code");
   a_main_top_entry: assert property (!$past(rst) |->
      main_top_priority == best($past(input_valid))) else $error("main top");
   a_main_sel_valid: assert property ($stable(input_valid) [*2] ##0
      main_selected != 4'h0 |-> input_valid[main_selected - 4'h1])
      else $error("main holds invalid input");
   a_aux_tracks_top: assert property ($stable(aux_top_priority) [*3]
      |-> aux_selected == aux_top_priority) else $error("aux not on top");
   a_force_code_ok: assert property (aux_forced_active |->
      aux_top_priority != 4'h0 && aux_top_priority != 4'h7 &&
      aux_top_priority <= 4'h9) else $error("bad forced input");
   a_route_apply: assert property (all_outputs_from_main ==
      aux_analog_freq_apply) else $error("routing mismatch");
   a_route_main: assert property (all_outputs_from_main |->
      aux_analog_from_main) else $error("analog not on main");
   a_freq_copy: assert property (!$past(rst) |-> aux_analog_freq_out ==
      $past(aux_analog_frequency)) else $error("aux frequency");
   a_pin_gated: assert property (out5_pin |-> $past(out5_clk_src))
      else $error("out5 without source");
   a_gpio_input: assert property (!$past(rst) |-> gpio_din ==
      $past(shared_pin_in)) else $error("gpio input");
   c_forced: cover property (aux_forced_active);
   c_nonrevert: cover property (main_selected != main_top_priority);
   c_follow: cover property (all_outputs_from_main);
endmodule : tsoc_cfg_properties
bind tsoc_cfg_top tsoc_cfg_properties u_props
(
   .core_clk, .rst, .input_valid, .input_freq_code, .input_rate_is_1544,
   .input_rate_is_2048, .main_selected, .main_top_priority, .aux_selected,
   .aux_top_priority, .aux_forced_active, .all_outputs_from_main,
   .aux_analog_from_main, .aux_analog_freq_apply, .aux_analog_frequency,
   .aux_analog_freq_out, .out5_clk_src, .out5_pin, .shared_pin_in, .gpio_din
);
`default_nettype wire

// file: tb/tsoc_cfg_top_test.sv
// self-checking bench of the configuration block
// assumes the package and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tsoc_cfg_top_test;
   import tsoc_pkg::*;
   logic core_clk, rst, reg_wr_en, reg_rd_en, rate_strap, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic aux_analog_source_select, aux_forced_active;
   logic [3:0] aux_analog_frequency, input_freq_code, aux_analog_freq_out, f;
   logic [8:0] input_valid;
   logic input_rate_is_1544, input_rate_is_2048;
   logic [3:0] main_selected, main_top_priority, aux_selected, aux_top_priority;
   logic all_outputs_from_main, aux_analog_from_main, aux_analog_freq_apply;
   logic out5_clk_src, out4_clk_src, out3_clk_src, out2_clk_src, out1_clk_src;
   logic out5_pin, out5b_pin, out4_pin, out4b_pin;
   logic [2:0] gpio_dout, gpio_oe_n, gpio_din, shared_pin_in, shared_pin_out;
   logic [2:0] shared_pin_oe_n, srcv;
   logic [7:0] shadow [4];
   int num_errors, tests_run, a;
   tsoc_cfg_top dut
   (
      .core_clk, .rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
      .reg_rdata, .reg_rvalid, .rate_strap, .aux_analog_source_select,
      .aux_analog_frequency, .input_valid, .input_freq_code,
      .input_rate_is_1544, .input_rate_is_2048, .main_selected,
      .main_top_priority, .aux_selected, .aux_top_priority,
      .aux_forced_active, .all_outputs_from_main, .aux_analog_from_main,
      .aux_analog_freq_out, .aux_analog_freq_apply, .out5_clk_src,
      .out4_clk_src, .out3_clk_src, .out2_clk_src, .out1_clk_src,
      .out5_pin, .out5b_pin, .out4_pin, .out4b_pin, .gpio_dout, .gpio_oe_n,
      .gpio_din,
      .shared_pin_in, .shared_pin_out, .shared_pin_oe_n
   );
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [3:0] best(input logic [8:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 8; i >= 0; i--)
      begin
         if (v[i] && i != TSOC_ABSENT_INPUT - 1)
         begin
            r = 4'(i + 1);
         end
      end
      return r;
   endfunction : best
   function automatic logic [7:0] msk(input int i);
      return i == 1 ? TSOC_AUXF_RD_MASK : i == 3 ? TSOC_OE_RD_MASK : 8'hff;
   endfunction : msk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
      begin
         $display("*** PASS ***");
      end
      else
      begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      reg_addr = ad;
      reg_wdata = v;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      reg_addr = ad;
      reg_rd_en = 1'b1;
      tick(1);
      reg_rd_en = 1'b0;
      chk({7'h0, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
      tick(1);
   endtask : rd_chk
   task automatic do_reset(input logic s);
      rst = 1'b1;
      rate_strap = s;
      tick(4);
      rst = 1'b0;
      rate_strap = ~s;
      shadow = '{{TSOC_RST_MODE[7:3], s, TSOC_RST_MODE[1:0]},
         TSOC_RST_AUX_FORCE, TSOC_RST_LEGACY, TSOC_RST_OUT_EN};
      tick(1);
   endtask : do_reset
   initial
   begin
      #200000;
      num_errors++;
      end_sim();
   end
   initial
   begin
      {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = '0;
      {aux_analog_source_select, aux_analog_frequency, input_freq_code} = '0;
      {input_valid, gpio_dout, gpio_oe_n, shared_pin_in} = '0;
      {out5_clk_src, out4_clk_src, out3_clk_src, out2_clk_src} = '0;
      out1_clk_src = 1'b0;
      num_errors = 0;
      tests_run = 0;
      d = 8'($urandom(31532));
      for (int s = 0; s < 2; s++)
      begin
         do_reset(s[0]);
         for (int i = 0; i < 5; i++)
         begin
            rd_chk(8'h34 + 8'(i), i < 4 ? shadow[i] : 8'h00);
         end
      end
      repeat (24)
      begin
         a = $urandom_range(0, 4);
         d = 8'($urandom);
         wr(8'h34 + 8'(a), d);
         if (a < 4)
         begin
            shadow[a] = d & msk(a);
         end
         rd_chk(8'h34 + 8'(a), a < 4 ? shadow[a] : 8'h00);
      end
      for (int b = 0; b < 2; b++)
      begin
         wr(TSOC_ADDR_MODE, {5'h19, b[0], 2'h2});
         for (int c = 0; c < 16; c++)
         begin
            input_freq_code = 4'(c);
            tick(2);
            chk({6'h0, input_rate_is_1544, input_rate_is_2048},
               {6'h0, c == 1 && b == 1, c == 1 && b == 0});
         end
      end
      input_freq_code = 4'h0;
      wr(TSOC_ADDR_AUX_FORCE, 8'h00);
      wr(TSOC_ADDR_MODE, 8'h01);
      repeat (12)
      begin
         input_valid = 9'($urandom);
         tick(3);
         chk({4'h0, main_selected}, {4'h0, best(input_valid)});
         chk({4'h0, aux_selected}, {4'h0, best(input_valid)});
      end
      wr(TSOC_ADDR_MODE, 8'h00);
      input_valid = 9'h010;
      tick(3);
      input_valid = 9'h012;
      tick(3);
      chk({main_selected, main_top_priority}, 8'h52);
      chk({4'h0, aux_selected}, 8'h02);
      input_valid = 9'h002;
      tick(3);
      chk({4'h0, main_selected}, 8'h02);
      for (int c = 0; c < 16; c++)
      begin
         input_valid = 9'($urandom) & ~(9'h1 << (4'(c) - 4'h1));
         wr(TSOC_ADDR_AUX_FORCE, 8'(c));
         tick(2);
         f = (c inside {[1:6], 8, 9}) ? 4'(c) : best(input_valid);
         chk({aux_selected, aux_top_priority}, {f, f});
         chk({7'h0, aux_forced_active}, {7'h0, c inside {[1:6], 8, 9}});
         chk({4'h0, main_top_priority}, {4'h0, best(input_valid)});
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(TSOC_ADDR_AUX_FORCE, {k[1], 7'h0});
         aux_analog_source_select = k[0];
         aux_analog_frequency = 4'($urandom);
         tick(2);
         chk({all_outputs_from_main, aux_analog_from_main,
            aux_analog_freq_apply, 1'b0, aux_analog_freq_out},
            {k == 2, k != 0, k == 2, 1'b0, aux_analog_frequency});
      end
      for (int i = 0; i < 16; i++)
      begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         wr(TSOC_ADDR_OUT_EN, d);
         {out5_clk_src, out4_clk_src, out3_clk_src} = 3'($urandom);
         {out2_clk_src, out1_clk_src} = 2'($urandom);
         {gpio_dout, gpio_oe_n, shared_pin_in} = 9'($urandom);
         srcv = {out3_clk_src, out2_clk_src, out1_clk_src};
         tick(2);
         chk({4'h0, out5_pin, out5b_pin, out4_pin, out4b_pin},
            {4'h0, d[6] & out5_clk_src, d[4] & out5_clk_src,
            d[5] & out4_clk_src, d[3] & out4_clk_src});
         chk({2'h0, shared_pin_out, shared_pin_oe_n},
            {2'h0, (d[2:0] & srcv) | (~d[2:0] & gpio_dout),
            ~d[2:0] & gpio_oe_n});
         chk({5'h0, gpio_din}, {5'h0, shared_pin_in});
      end
      end_sim();
   end
endmodule : tsoc_cfg_top_test
`default_nettype wire
